// [hw/sequencer_pkg.sv]
package sequencer_pkg;

    // Register indices; byte address is four times the index
    localparam logic [2:0] REG0_IDX = 3'h0;
    localparam logic [2:0] REG2_IDX = 3'h2;
    localparam logic [2:0] REG3_IDX = 3'h3;
    localparam logic [2:0] STAT_IDX = 3'h4;

    // Field positions
    localparam int ENA_BIT = 0;
    localparam int CONV_LSB = 16;
    localparam int ONESHOT_BIT = 2;
    localparam int CYT_LSB = 4;
    localparam int AVG_LSB = 14;
    localparam int BRIDGE_LSB = 0;
    localparam int SPREAD_LSB = 12;
    localparam int LEAD_LSB = 17;

    // Reset values
    localparam logic [31:0] CFG0_RST = 32'h0000_0000;
    localparam logic [31:0] CFG2_RST = 32'h0000_0000;
    localparam logic [31:0] CFG3_RST = 32'h0000_0000;

    // Timing
    localparam int CLK_MHZ = 25;
    localparam int FAST_STEP_NS = 2000;
    localparam int FAST_STEP_CYC = FAST_STEP_NS * CLK_MHZ / 1000;
    localparam int SLOW_TICK_US = 100;
    localparam int SEP2_US = 200;
    localparam int SEP3_US = 300;
    localparam int SEP2_TICKS = SEP2_US / SLOW_TICK_US;
    localparam int SEP3_TICKS = SEP3_US / SLOW_TICK_US;
    localparam int CONV_STEP_US = 6400;
    localparam int CONV_STEP_TICKS = CONV_STEP_US / SLOW_TICK_US;

    // Discharges per ratio sample
    localparam logic [3:0] CYC_HALF = 4'h2;
    localparam logic [3:0] CYC_FULL = 4'h4;
    localparam logic [3:0] CYC_QUAT = 4'h8;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_LEAD = 3'b001,
        ST_DISCH = 3'b010,
        ST_SEP = 3'b011,
        ST_GAP = 3'b100,
        ST_WAIT = 3'b101,
        ST_SLEEP = 3'b110
    } seq_state_e;

    typedef enum logic [1:0] {
        MODE_CONT = 2'b00,
        MODE_SINGLE = 2'b01,
        MODE_SCONT = 2'b10,
        MODE_SSINGLE = 2'b11
    } op_mode_e;

    typedef struct packed {
        logic wr;
        logic map;
        logic [2:0] idx;
    } ahb_aph_s;

endpackage : sequencer_pkg

// [hw/measurement_mode_sequencer.sv]
`timescale 1ns/1ns

// Operation
// - continuous: back-to-back discharges, oscillator always on
// - one-shot: one sequence, oscillator off, sleep
// - one-shot select is bit 2, config 2
// - spread field bits 13:12 config 3
// - spread one: oscillator per discharge, slow gaps
// - spread two/three: oscillator per pair
// - pair separation 200 or 300 us
// - cycle interval bits 13:4, 100 us steps spread
// - lead time field bits 19:17 config 3
// - period count bits 23:16 config 0
// - averaging count sets ratio samples per sequence
// - spread single: pair, then cycle interval
// - mode from one-shot and spread together
// - non-spread interval in 2 us steps
// - sample is 2, 4 or 8 discharges
// - period count step is 6.4 ms
module measurement_mode_sequencer
    import sequencer_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic slow_tick,
    input wire logic discharge_done,
    output logic fast_osc_en,
    output logic discharge_start,
    output logic sequence_done
);

    typedef struct packed {
        seq_state_e st;
        logic [15:0] cnt;
        logic [15:0] per;
        logic [15:0] nd;
        logic half;
        logic osc;
        logic go;
        logic done;
        logic rdy;
        logic [31:0] cfg0;
        logic [31:0] cfg2;
        logic [31:0] cfg3;
        ahb_aph_s aph;
        logic [31:0] rdata;
    } seq_regs_s;

    localparam seq_regs_s REGS_RST = '{
        st: ST_IDLE,
        rdy: 1'b1,
        cfg0: CFG0_RST,
        cfg2: CFG2_RST,
        cfg3: CFG3_RST,
        default: '0
    };

    seq_regs_s st_r;
    seq_regs_s st_nxt;

    ////////////////////////////////////////////////////////////////////////
    // Configuration decode

    logic ena;
    logic oneshot;
    logic [1:0] spread;
    logic spread_on;
    logic [9:0] cytime;
    logic [9:0] avg;
    logic [2:0] lead;
    logic [7:0] conv;
    logic [3:0] cps;
    op_mode_e mode;
    logic [15:0] cyc_t;
    logic [15:0] fast_t;
    logic [15:0] lead_t;
    logic [15:0] sep_t;
    logic [15:0] conv_t;
    logic [15:0] total;
    logic [15:0] nd_inc;

    // Fields
    assign ena = st_r.cfg0[ENA_BIT];
    assign conv = st_r.cfg0[CONV_LSB +: 8];
    assign oneshot = st_r.cfg2[ONESHOT_BIT];
    assign cytime = st_r.cfg2[CYT_LSB +: 10];
    assign avg = st_r.cfg2[AVG_LSB +: 10];
    assign spread = st_r.cfg3[SPREAD_LSB +: 2];
    assign lead = st_r.cfg3[LEAD_LSB +: 3];
    assign spread_on = (spread != 2'b00);
    assign mode = op_mode_e'({spread_on, oneshot});

    // Discharges per sample
    always_comb begin
        case (st_r.cfg3[BRIDGE_LSB +: 2])
            2'b00: cps = CYC_HALF;
            2'b01: cps = CYC_FULL;
            default: cps = CYC_QUAT;
        endcase
    end

    // Wait targets, none below one step; a zero period count gives one slow tick
    assign cyc_t = (cytime == 10'h000) ? 16'h0001 : {6'h00, cytime};
    assign fast_t = (cytime == 10'h000) ? 16'(FAST_STEP_CYC)
                  : 16'(cytime * 16'(FAST_STEP_CYC));
    assign lead_t = (lead == 3'h0) ? 16'h0001 : {13'h0000, lead};
    assign sep_t = spread[0] ? 16'(SEP3_TICKS) : 16'(SEP2_TICKS);
    assign conv_t = (conv == 8'h00) ? 16'h0001
                  : 16'(conv * 16'(CONV_STEP_TICKS));
    assign total = {6'h00, ((avg == 10'h000) ? 10'h001 : avg)} * {12'h000, cps};
    assign nd_inc = st_r.nd + 16'h0001;

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        st_nxt = st_r;
        st_nxt.go = 1'b0;
        st_nxt.done = 1'b0;
        st_nxt.rdy = 1'b1;

        // Data phase of a write
        if (st_r.aph.wr && st_r.aph.map) begin
            case (st_r.aph.idx)
                REG0_IDX: st_nxt.cfg0 = hwdata;
                REG2_IDX: st_nxt.cfg2 = hwdata;
                REG3_IDX: st_nxt.cfg3 = hwdata;
                default: st_nxt.cfg0 = st_r.cfg0;
            endcase
        end

        // Period counter runs on the slow clock
        if (slow_tick && st_r.per != 16'hFFFF) begin
            st_nxt.per = st_r.per + 16'h0001;
        end

        case (st_r.st)
            ST_IDLE: begin
                st_nxt.nd = 16'h0000;
                st_nxt.per = 16'h0000;
                st_nxt.half = 1'b0;
                st_nxt.cnt = 16'h0000;
                if (ena) begin
                    st_nxt.osc = 1'b1;
                    if (spread_on) begin
                        st_nxt.st = ST_LEAD;
                    end else begin
                        st_nxt.st = ST_DISCH;
                        st_nxt.go = 1'b1;
                    end
                end
            end
            ST_LEAD: begin
                if (slow_tick) begin
                    if (st_r.cnt + 16'h0001 >= lead_t) begin
                        st_nxt.st = ST_DISCH;
                        st_nxt.go = 1'b1;
                        st_nxt.cnt = 16'h0000;
                    end else begin
                        st_nxt.cnt = st_r.cnt + 16'h0001;
                    end
                end
            end
            ST_SEP: begin
                if (slow_tick) begin
                    if (st_r.cnt + 16'h0001 >= sep_t) begin
                        st_nxt.st = ST_DISCH;
                        st_nxt.go = 1'b1;
                        st_nxt.cnt = 16'h0000;
                    end else begin
                        st_nxt.cnt = st_r.cnt + 16'h0001;
                    end
                end
            end
            ST_GAP: begin
                if (slow_tick) begin
                    if (st_r.cnt + 16'h0001 >= cyc_t) begin
                        st_nxt.st = ST_LEAD;
                        st_nxt.osc = 1'b1;
                        st_nxt.cnt = 16'h0000;
                    end else begin
                        st_nxt.cnt = st_r.cnt + 16'h0001;
                    end
                end
            end
            ST_WAIT: begin
                if (st_r.cnt + 16'h0001 >= fast_t) begin
                    st_nxt.st = ST_DISCH;
                    st_nxt.go = 1'b1;
                    st_nxt.cnt = 16'h0000;
                end else begin
                    st_nxt.cnt = st_r.cnt + 16'h0001;
                end
            end
            ST_DISCH: begin
                if (discharge_done) begin
                    st_nxt.cnt = 16'h0000;
                    if (nd_inc >= total) begin
                        st_nxt.done = 1'b1;
                        st_nxt.nd = 16'h0000;
                        st_nxt.half = 1'b0;
                    end else begin
                        st_nxt.nd = nd_inc;
                    end
                    if (nd_inc >= total && oneshot) begin
                        st_nxt.st = ST_SLEEP;
                        st_nxt.osc = 1'b0;
                    end else if (spread[1] && !st_r.half && nd_inc < total) begin
                        st_nxt.half = 1'b1;
                        st_nxt.st = ST_SEP;
                    end else if (spread_on) begin
                        st_nxt.half = 1'b0;
                        st_nxt.st = ST_GAP;
                        st_nxt.osc = 1'b0;
                    end else begin
                        st_nxt.st = ST_WAIT;
                    end
                    if (nd_inc >= total && !oneshot) begin
                        st_nxt.per = 16'h0000;
                    end
                end
            end
            ST_SLEEP: begin
                if (st_r.per >= conv_t) begin
                    st_nxt.per = 16'h0000;
                    st_nxt.osc = 1'b1;
                    st_nxt.cnt = 16'h0000;
                    if (spread_on) begin
                        st_nxt.st = ST_LEAD;
                    end else begin
                        st_nxt.st = ST_DISCH;
                        st_nxt.go = 1'b1;
                    end
                end
            end
            default: begin
                st_nxt.st = ST_IDLE;
                st_nxt.osc = 1'b0;
            end
        endcase

        // Disable forces idle, oscillator off and no start pulse
        if (!ena) begin
            st_nxt.st = ST_IDLE;
            st_nxt.osc = 1'b0;
            st_nxt.go = 1'b0;
        end

        // Address phase; read data from updated values
        st_nxt.aph.wr = 1'b0;
        if (hsel && hready && htrans[1]) begin
            st_nxt.aph.map = (haddr[31:5] == 27'h0000000);
            st_nxt.aph.idx = haddr[4:2];
            st_nxt.aph.wr = hwrite;
            st_nxt.rdata = 32'h0000_0000;
            if (!hwrite && haddr[31:5] == 27'h0000000) begin
                case (haddr[4:2])
                    REG0_IDX: st_nxt.rdata = st_nxt.cfg0;
                    REG2_IDX: st_nxt.rdata = st_nxt.cfg2;
                    REG3_IDX: st_nxt.rdata = st_nxt.cfg3;
                    STAT_IDX: st_nxt.rdata = {st_nxt.nd, 11'h000, st_nxt.half,
                                              st_nxt.osc, st_nxt.st};
                    default: st_nxt.rdata = 32'h0000_0000;
                endcase
            end
        end
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r <= REGS_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs
    assign hreadyout = st_r.rdy;
    assign hresp = 1'b0;
    assign hrdata = st_r.rdata;
    assign fast_osc_en = st_r.osc;
    assign discharge_start = st_r.go;
    assign sequence_done = st_r.done;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    a_cont_osc_on: assert property (
        (mode == MODE_CONT && st_r.st == ST_WAIT) |-> fast_osc_en)
        else $error("oscillator off in continuous wait");
    a_sleep_osc_off: assert property (
        (st_r.st == ST_SLEEP) |-> !fast_osc_en)
        else $error("oscillator on while sleeping");
    a_oneshot_sleep: assert property (
        (st_r.st == ST_DISCH && discharge_done && nd_inc >= total && oneshot && ena)
        |=> (st_r.st == ST_SLEEP && sequence_done))
        else $error("one-shot sequence did not sleep");
    a_mode_decode: assert property (
        (st_r.st == ST_IDLE && ena)
        |=> (st_r.st == ST_LEAD) == $past(st_r.cfg3[SPREAD_LSB +: 2] != 2'b00))
        else $error("mode decode wrong");
    a_gap_osc_off: assert property (
        (st_r.st == ST_GAP) |-> !fast_osc_en)
        else $error("oscillator on during slow gap");
    a_pair_osc_on: assert property (
        (st_r.st == ST_SEP) |-> fast_osc_en)
        else $error("oscillator off inside pair");
    a_pair_sep: assert property (
        (st_r.st == ST_SEP && st_nxt.st == ST_DISCH)
        |-> (slow_tick && st_r.cnt + 16'h0001 == sep_t))
        else $error("pair separation wrong");
    a_lead_time: assert property (
        (st_r.st == ST_LEAD ##1 st_r.st == ST_DISCH)
        |-> $past(st_r.cnt) + 16'h0001 == $past(lead_t))
        else $error("discharge before lead time");
    a_fast_wait: assert property (
        (st_r.st == ST_WAIT && st_nxt.st == ST_DISCH && ena)
        |-> st_r.cnt + 16'h0001 == fast_t)
        else $error("fast cycle interval wrong");
    a_seq_total: assert property (
        sequence_done |-> $past(st_r.nd) + 16'h0001 == $past(total))
        else $error("sequence length wrong");
    a_wake_osc: assert property (
        (st_r.st == ST_SLEEP && st_r.per >= conv_t && ena)
        |=> (fast_osc_en && st_r.st != ST_SLEEP))
        else $error("no wake after period");
    a_go_pulse: assert property (
        discharge_start |=> !discharge_start)
        else $error("start pulse too long");

    c_sleep_wake: cover property (st_r.st == ST_SLEEP ##1 st_r.st != ST_SLEEP);
    c_pair_second: cover property (st_r.st == ST_SEP ##1 discharge_start);
    c_scont_done: cover property (sequence_done && mode == MODE_SCONT);

endmodule : measurement_mode_sequencer

// [dv/front_end_model.sv]
`timescale 1ns/1ns
module front_end_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic discharge_start,
    input wire logic fast_osc_en,
    output logic discharge_done,
    output logic slow_tick
);
    int unsigned tcnt;
    int unsigned dly;

    // Slow oscillator, one tick every 8 clocks
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tcnt <= 0;
            slow_tick <= 1'b0;
        end else begin
            tcnt <= (tcnt == 7) ? 0 : tcnt + 1;
            slow_tick <= (tcnt == 7);
        end
    end

    // Discharge ends 2 to 17 clocks after start, only with oscillator up
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dly <= 0;
            discharge_done <= 1'b0;
        end else begin
            discharge_done <= (dly == 1);
            if (discharge_start && fast_osc_en) begin
                dly <= 1 + $urandom % 16;
            end else if (dly != 0) begin
                dly <= dly - 1;
            end
        end
    end
endmodule : front_end_model

// [dv/tb_measurement_mode_sequencer.sv]
`timescale 1ns/1ns
module tb_measurement_mode_sequencer;
    import sequencer_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp, slow_tick, discharge_done;
    logic fast_osc_en, discharge_start, sequence_done;
    logic [31:0] hrdata;
    logic rd_dphase = 1'b0;
    logic osc_q = 1'b0;
    int n_errors = 0;
    int cmp_count = 0;
    logic [31:0] exp_rd[$];
    int exp_gap[$];
    int exp_len[$];
    int spr, per_min, per_max, ticks, cycs, pticks, nstart, rises, ndone;

    initial forever #20 hclk = ~hclk;

    measurement_mode_sequencer u_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .slow_tick(slow_tick),
        .discharge_done(discharge_done), .fast_osc_en(fast_osc_en),
        .discharge_start(discharge_start), .sequence_done(sequence_done)
    );

    front_end_model u_fe (
        .hclk(hclk), .hresetn(hresetn), .discharge_start(discharge_start),
        .fast_osc_en(fast_osc_en), .discharge_done(discharge_done),
        .slow_tick(slow_tick)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
        cmp_count++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask : chk

    // Single AHB transfer, address phase then data phase
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        rd_dphase <= !wr;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd_dphase <= 1'b0;
    endtask : ahb

    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        exp_rd.push_back(e);
        ahb(1'b0, a, 32'h0);
    endtask : rd

    // One mode run: note expectations, configure, enable, wait, stop
    task automatic run(input int os, sp, cyt, avg, br, lead, conv, nseq);
        int len, n, ce, le, er;
        ce = (cyt == 0) ? 1 : cyt;
        le = (lead == 0) ? 1 : lead;
        len = avg * ((br == 0) ? 2 : (br == 1) ? 4 : 8);
        exp_gap.delete();
        exp_len.delete();
        spr = sp;
        rises = 0;
        ndone = 0;
        nstart = 0;
        per_min = os ? conv * CONV_STEP_TICKS : 0;
        per_max = per_min + (sp ? le : 0) + 1;
        for (int s = 0; s < nseq; s++) begin
            exp_len.push_back(len);
            for (int k = 1; k < len; k++) begin
                exp_gap.push_back(sp == 0 ? ce * FAST_STEP_CYC : (sp > 1 && k % 2)
                    ? (sp == 2 ? SEP2_TICKS : SEP3_TICKS) : ce + le);
            end
        end
        er = sp == 0 ? (os ? nseq : 1) : sp == 1 ? nseq * len : nseq * len / 2;
        ahb(1'b1, 32'h0C, 32'((sp << SPREAD_LSB) | (lead << LEAD_LSB) | br));
        ahb(1'b1, 32'h08, 32'((os << ONESHOT_BIT) | (cyt << CYT_LSB) | (avg << AVG_LSB)));
        ahb(1'b1, 32'h00, 32'((conv << CONV_LSB) | 1));
        n = 0;
        while (ndone < nseq && n < 20000) begin
            @(posedge hclk);
            n++;
        end
        ahb(1'b1, 32'h00, 32'h0);
        chk(32'(ndone), 32'(nseq), 32'(nseq));
        chk(32'(rises), 32'(er), 32'(er));
        repeat (40) @(posedge hclk);
    endtask : run

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_of_test

    ////////////////////////////////////////////////////////////////////////
    // Result watcher: read data, gaps, periods and sequence lengths
    always @(posedge hclk) begin : mon
        int g;
        if (rd_dphase && hreadyout === 1'b1 && exp_rd.size() > 0) begin
            chk(hrdata, exp_rd[0], exp_rd[0]);
            chk(32'(hresp), 32'h0, 32'h0);
            void'(exp_rd.pop_front());
        end
        cycs++;
        if (slow_tick === 1'b1) begin
            ticks++;
            pticks++;
        end
        if (fast_osc_en === 1'b1 && osc_q !== 1'b1) rises++;
        osc_q = fast_osc_en;
        if (discharge_done === 1'b1) begin
            cycs = 0;
            ticks = 0;
        end
        if (discharge_start === 1'b1) begin
            chk(32'(fast_osc_en), 32'h1, 32'h1);
            if (nstart == 0) begin
                if (per_min > 0 && ndone > 0) chk(pticks, per_min, per_max);
                pticks = (slow_tick === 1'b1) ? 1 : 0;
            end else if (exp_gap.size() > 0) begin
                g = exp_gap.pop_front();
                chk(spr == 0 ? cycs : ticks, g, g + (spr == 0 ? 3 : 1));
            end
            nstart++;
        end
        if (sequence_done === 1'b1) begin
            if (exp_len.size() > 0) begin
                chk(nstart, exp_len[0], exp_len[0]);
                void'(exp_len.pop_front());
            end
            nstart = 0;
            ndone++;
        end
    end

    // Hang guard
    initial begin
        repeat (60000) @(posedge hclk);
        n_errors++;
        end_of_test();
    end

    // Main sequence
    initial begin
        logic [31:0] v;
        void'($urandom(32'hDC23D984));
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        hsel <= 1'b1;
        rd(32'h00, CFG0_RST);
        rd(32'h08, CFG2_RST);
        rd(32'h0C, CFG3_RST);
        rd(32'h10, 32'h0);
        // Unmapped places read zero and ignore writes
        ahb(1'b1, 32'h04, 32'hFFFF_FFFF);
        ahb(1'b1, 32'h20, 32'hFFFF_FFFF);
        rd(32'h04, 32'h0);
        rd(32'h00, 32'h0);
        rd(32'h1C, 32'h0);
        for (int i = 0; i < 4; i++) begin
            v = $urandom & 32'h00FF_FFF4;
            ahb(1'b1, 32'h08, v);
            rd(32'h08, v);
            v = $urandom & 32'h000F_3003;
            ahb(1'b1, 32'h0C, v);
            rd(32'h0C, v);
            v = $urandom & 32'h00FF_0000;
            ahb(1'b1, 32'h00, v);
            rd(32'h00, v);
        end
        run(0, 0, 1 + $urandom % 4, 2, 0, 1, 1, 2);
        run(1, 0, 0, 1, 1, 1, 1, 2);
        run(0, 2, 3, 1, 0, 2, 1, 2);
        run(1, 3, 1, 2, 1, 0, 1, 2);
        run(0, 1, 2, 1, 2, 1, 1, 1);
        end_of_test();
    end
endmodule : tb_measurement_mode_sequencer
